// >>> include/bib_pkg.sv
// Package for the bus information block register bank: offsets, layouts, codes.
package bib_pkg;

    // Register byte offsets on the local register port
    localparam logic [7:0] BIB_OFS_BUS_OPTIONS = 8'h00;
    localparam logic [7:0] BIB_OFS_UID_HIGH    = 8'h04;
    localparam logic [7:0] BIB_OFS_UID_LOW     = 8'h08;
    localparam logic [7:0] BIB_OFS_ROM_MAP     = 8'h0c;
    localparam logic [7:0] BIB_OFS_VENDOR_ID   = 8'h10;
    localparam logic [7:0] BIB_OFS_LINK_CTRL   = 8'h14;
    localparam logic [7:0] BIB_OFS_STATUS      = 8'h18;

    // Reset values
    localparam logic [31:0] BIB_RST_BUS_OPTIONS = 32'h0000_0000;
    localparam logic [31:0] BIB_RST_UID         = 32'h0000_0000;
    localparam logic [31:0] BIB_RST_ROM_MAP     = 32'h0000_0000;

    // Bus options fields that firmware may program
    localparam int BIB_MAXREC_LSB = 12;
    localparam int BIB_MAXREC_W   = 4;

    // Mapping base keeps the low ten bits as zero
    localparam int BIB_MAP_ALIGN_BITS = 10;
    localparam logic [31:0] BIB_MAP_MASK = 32'hffff_fc00;

    // Configuration ROM window on the serial bus
    localparam logic [47:0] BIB_ROM_START = 48'hffff_f000_0400;
    localparam logic [47:0] BIB_ROM_END   = 48'hffff_f000_07ff;
    localparam logic [7:0]  BIB_LOCAL_QUADS = 8'h05;

    // Fixed first quadlet of the information block: bus name in ASCII
    localparam logic [31:0] BIB_BUS_ID = 32'h3133_3934;

    // Vendor identification fields
    localparam logic [23:0] BIB_EXT_OWNER_CODE   = 24'h00_0000;
    localparam logic [7:0]  BIB_EXT_PRIVATE_DEF  = 8'h00; // arbitrary value

    // Serial bus transaction codes and answer kinds
    localparam logic [3:0] BIB_TC_QREAD  = 4'h4;
    localparam logic [3:0] BIB_TC_BWRITE = 4'h1;

    // Remote request toward the register bank
    typedef struct packed {
        logic        valid;
        logic [3:0]  tcode;
        logic [47:0] offset;
        logic [15:0] length;
    } bib_req_type;

    // Answer for a remote request
    typedef enum logic [3:0] {
        BIB_ANS_NONE   = 4'b0001,
        BIB_ANS_LOCAL  = 4'b0010,
        BIB_ANS_HOST   = 4'b0100,
        BIB_ANS_TYPERR = 4'b1000
    } bib_ans_type;

    typedef struct packed {
        bib_ans_type kind;
        logic [31:0] data;
        logic [31:0] host_addr;
    } bib_rsp_type;

    // Loader states for the unique identifier
    typedef enum logic [2:0] {
        BIB_UID_EMPTY  = 3'b001,
        BIB_UID_FETCH  = 3'b010,
        BIB_UID_LOCKED = 3'b100
    } bib_uid_state_type;

endpackage : bib_pkg

// >>> verilog/bib_regs.sv
// Bus information block register bank with remote ROM window decode.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps

module bib_regs
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    // Software reset pulse from the control block
    input  wire logic                  soft_reset,
    // Local register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [31:0]                reg_rdata,
    // Identifier ROM loader
    input  wire logic                  rom_present,
    input  wire logic                  rom_valid,
    input  wire logic [63:0]           rom_uid,
    output logic                       rom_fetch,
    // Configuration ROM header quadlet from its own register
    input  wire logic [31:0]           rom_header,
    // Remote request and answer
    input  wire bib_pkg::bib_req_type  remote_req,
    output bib_pkg::bib_rsp_type       remote_rsp,
    // Link state
    output logic                       link_on
);
    import bib_pkg::*;

    logic [31:0]       bus_options_ff;
    logic [31:0]       unique_id_high;
    logic [31:0]       unique_id_low;
    logic [31:0]       rom_map_base_ff;
    logic              link_on_ff;
    logic              wr_hi_done;
    logic              wr_lo_done;
    logic              rom_load;
    bib_uid_state_type uid_state_ff;
    bib_uid_state_type nxt_uid_state;
    logic [31:0]       reg_rdata_ff;
    logic              rom_fetch_ff;
    bib_rsp_type       remote_rsp_ff;
    bib_rsp_type       nxt_rsp;

    // Register write decode
    wire wr_opt  = reg_wr && (reg_addr == BIB_OFS_BUS_OPTIONS);
    wire wr_hi   = reg_wr && (reg_addr == BIB_OFS_UID_HIGH);
    wire wr_lo   = reg_wr && (reg_addr == BIB_OFS_UID_LOW);
    wire wr_map  = reg_wr && (reg_addr == BIB_OFS_ROM_MAP);
    wire wr_link = reg_wr && (reg_addr == BIB_OFS_LINK_CTRL);
    // Each half takes one firmware write, only while the loader is still empty
    wire uid_open = (uid_state_ff == BIB_UID_EMPTY);
    wire hi_take  = wr_hi && uid_open && !wr_hi_done;
    wire lo_take  = wr_lo && uid_open && !wr_lo_done;
    wire fw_done  = (wr_hi_done || hi_take) && (wr_lo_done || lo_take);
    // ROM copy lands on the edge that ends the fetch
    assign rom_load = (uid_state_ff == BIB_UID_FETCH) && rom_valid;

    // Vendor word is constant; nothing can write it
    wire [31:0] vendor_word = {BIB_EXT_PRIVATE_DEF, BIB_EXT_OWNER_CODE};
    wire [31:0] status_word = {29'h0, uid_state_ff};

    // Read selects, one per mapped offset
    // Compared once here and shared by the mux below
    wire rd_opt    = (reg_addr == BIB_OFS_BUS_OPTIONS);
    wire rd_hi     = (reg_addr == BIB_OFS_UID_HIGH);
    wire rd_lo     = (reg_addr == BIB_OFS_UID_LOW);
    wire rd_map    = (reg_addr == BIB_OFS_ROM_MAP);
    wire rd_vendor = (reg_addr == BIB_OFS_VENDOR_ID);
    wire rd_link   = (reg_addr == BIB_OFS_LINK_CTRL);
    wire rd_status = (reg_addr == BIB_OFS_STATUS);

    // Read data mux; unmapped reads return zero so probing is harmless
    wire [31:0] rd_mux =
        rd_opt    ? bus_options_ff :
        rd_hi     ? unique_id_high :
        rd_lo     ? unique_id_low :
        rd_map    ? rom_map_base_ff :
        rd_vendor ? vendor_word :
        rd_link   ? {31'h0, link_on_ff} :
        rd_status ? status_word : 32'h0;

    // Remote request decode
    wire [47:0] rq_ofs   = remote_req.offset;
    wire        in_rom   = (rq_ofs >= BIB_ROM_START) && (rq_ofs <= BIB_ROM_END);
    wire        is_qread = (remote_req.tcode == BIB_TC_QREAD);
    wire [7:0]  quad_idx = rq_ofs[9:2];
    wire        is_local = (quad_idx < BIB_LOCAL_QUADS);
    wire [BIB_MAXREC_W-1:0] max_rec = bus_options_ff[BIB_MAXREC_LSB +: BIB_MAXREC_W];
    wire        is_bwrite = (remote_req.tcode == BIB_TC_BWRITE);
    // Max receive size in bytes is 2^(max_rec+1); widened first so that
    // a field of 15 gives 64K bytes instead of wrapping to a shift of 0
    wire [4:0]  rec_shift = {1'b0, max_rec} + 5'h01;
    wire [16:0] max_bytes = 17'h00001 << rec_shift;
    wire        too_long  = is_bwrite &&
                            ({1'b0, remote_req.length} > max_bytes);
    wire [31:0] host_addr = rom_map_base_ff +
                            {22'h0, rq_ofs[BIB_MAP_ALIGN_BITS-1:0]};

    // Local answer for the five locally answered quadlets; the header comes in on rom_header
    wire [31:0] local_word =
        (quad_idx == 8'h00) ? rom_header :
        (quad_idx == 8'h01) ? BIB_BUS_ID :
        (quad_idx == 8'h02) ? bus_options_ff :
        (quad_idx == 8'h03) ? unique_id_high :
        unique_id_low;

    // Answer selection; silent while the link is off
    always_comb begin
        nxt_rsp = '{kind: BIB_ANS_NONE, data: 32'h0, host_addr: 32'h0};
        if (remote_req.valid && link_on_ff) begin
            if (in_rom && is_qread && is_local) begin
                nxt_rsp.kind = BIB_ANS_LOCAL;
                nxt_rsp.data = local_word;
            end else if (in_rom && is_qread) begin
                nxt_rsp.kind      = BIB_ANS_HOST;
                nxt_rsp.host_addr = host_addr;
            end else if (in_rom || too_long) begin
                nxt_rsp.kind = BIB_ANS_TYPERR;
            end
        end
    end

    // Identifier loader: ROM fetch or two firmware writes, then locked
    always_comb begin
        nxt_uid_state = uid_state_ff;
        unique case (uid_state_ff)
            BIB_UID_EMPTY: begin
                if (rom_present) begin
                    nxt_uid_state = BIB_UID_FETCH;
                end else if (fw_done) begin
                    nxt_uid_state = BIB_UID_LOCKED;
                end
            end
            BIB_UID_FETCH: begin
                if (rom_valid) begin
                    nxt_uid_state = BIB_UID_LOCKED;
                end
            end
            BIB_UID_LOCKED: nxt_uid_state = BIB_UID_LOCKED;
            default:        nxt_uid_state = BIB_UID_LOCKED;
        endcase
    end

    // Loader state, cleared only by power reset; a soft reset must not
    // reopen the identifier to writes
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            uid_state_ff <= BIB_UID_EMPTY;
        end else begin
            // Soft reset deliberately not consulted here
            uid_state_ff <= nxt_uid_state;
        end
    end

    // Upper identifier half; soft reset is not wired in,
    // the value has to survive one
    bib_uid_half #(
        .WIDTH    (32),
        .RST_VAL  (BIB_RST_UID)
    ) i_bib_uid_half_hi (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .rom_load (rom_load),
        .rom_data (rom_uid[63:32]),
        .fw_write (hi_take),
        .fw_data  (reg_wdata),
        .value    (unique_id_high),
        .written  (wr_hi_done)
    );

    // Lower identifier half, same rules as the upper one
    bib_uid_half #(
        .WIDTH    (32),
        .RST_VAL  (BIB_RST_UID)
    ) i_bib_uid_half_lo (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .rom_load (rom_load),
        .rom_data (rom_uid[31:0]),
        .fw_write (lo_take),
        .fw_data  (reg_wdata),
        .value    (unique_id_low),
        .written  (wr_lo_done)
    );

    // Options, mapping base and link bit; soft reset restores them
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bus_options_ff  <= BIB_RST_BUS_OPTIONS;
            rom_map_base_ff <= BIB_RST_ROM_MAP;
            link_on_ff      <= 1'b0;
        end else if (soft_reset) begin
            bus_options_ff  <= BIB_RST_BUS_OPTIONS;
            rom_map_base_ff <= BIB_RST_ROM_MAP;
            link_on_ff      <= 1'b0;
        end else begin
            if (wr_opt) begin
                bus_options_ff <= reg_wdata;
            end
            if (wr_map) begin
                rom_map_base_ff <= reg_wdata & BIB_MAP_MASK;
            end
            if (wr_link) begin
                link_on_ff <= reg_wdata[0];
            end
        end
    end

    // Registered outputs
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_ff  <= 32'h0;
            rom_fetch_ff  <= 1'b0;
            remote_rsp_ff <= '{kind: BIB_ANS_NONE, data: 32'h0, host_addr: 32'h0};
        end else begin
            reg_rdata_ff  <= reg_rd ? rd_mux : 32'h0;
            rom_fetch_ff  <= (nxt_uid_state == BIB_UID_FETCH);
            remote_rsp_ff <= nxt_rsp;
        end
    end

    assign reg_rdata  = reg_rdata_ff;
    assign rom_fetch  = rom_fetch_ff;
    assign remote_rsp = remote_rsp_ff;
    assign link_on    = link_on_ff;

endmodule : bib_regs

// One identifier half: power reset clears it, then a single load fills it.
// The parent only lets one source in at a time, so no priority is needed.
// Kept apart so both halves share one piece of write-once logic.
module bib_uid_half #(
    parameter int               WIDTH   = 32,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and power reset
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    // Autonomous copy from the identifier ROM
    input  wire logic             rom_load,
    input  wire logic [WIDTH-1:0] rom_data,
    // Single firmware write, already gated by the parent
    input  wire logic             fw_write,
    input  wire logic [WIDTH-1:0] fw_data,
    // Stored half and its written flag
    output logic [WIDTH-1:0]      value,
    output logic                  written
);
    logic [WIDTH-1:0] value_ff;
    logic             written_ff;
    logic [WIDTH-1:0] nxt_value;
    logic             take;

    // Load source; the two are never open in one loader state
    assign nxt_value = rom_load ? rom_data : fw_data;
    assign take      = rom_load || fw_write;

    // Storage, reset only by power reset
    // A soft reset never reaches this flop
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            value_ff <= RST_VAL;
        end else if (take) begin
            value_ff <= nxt_value;
        end
    end

    // Firmware write marker; once set, the parent refuses that half
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            written_ff <= 1'b0;
        end else if (fw_write) begin
            written_ff <= 1'b1;
        end
    end

    assign value   = value_ff;
    assign written = written_ff;

endmodule : bib_uid_half

// >>> sim/bib_rom_model.sv
// Identifier ROM model: answers a fetch after a set access time.
`timescale 1ns/1ps
module bib_rom_model #(
    parameter logic [63:0] UID = 64'h0123_4567_89ab_cdef, // Arbitrary nonzero value
    parameter int          DLY = 3
) (
    // Clock
    input  wire logic        ref_clk,
    // Fitted flag and fetch request
    input  wire logic        fitted,
    input  wire logic        rom_fetch,
    // Answer toward the bank
    output logic             rom_present,
    output logic             rom_valid,
    output logic [63:0]      rom_uid
);
    int cnt_ff = 0;
    // Access time counter; data only holds while valid
    always @(posedge ref_clk) cnt_ff <= (rom_fetch && fitted) ? cnt_ff + 1 : 0;
    assign rom_present = fitted;
    assign rom_valid = fitted && cnt_ff == DLY;
    // Inverse outside valid, so a stale read shows up
    assign rom_uid = rom_valid ? UID : ~UID;
endmodule : bib_rom_model

// >>> sim/bib_regs_properties.sv
// Concurrent checks on the information block register bank ports.
`timescale 1ns/1ps
module bib_regs_chk
    import bib_pkg::*;
(
    // Clock and resets
    input wire logic                 ref_clk,
    input wire logic                 resetn,
    input wire logic                 soft_reset,
    // Register port
    input wire logic [7:0]           reg_addr,
    input wire logic                 reg_rd,
    input wire logic [31:0]          reg_rdata,
    // Remote side
    input wire bib_pkg::bib_req_type remote_req,
    input wire bib_pkg::bib_rsp_type remote_rsp,
    input wire logic                 link_on
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Request classes, judged only while the link is on
    wire qrd = remote_req.valid && link_on && remote_req.tcode == BIB_TC_QREAD;
    wire inr = remote_req.offset >= BIB_ROM_START && remote_req.offset <= BIB_ROM_END;
    wire head = remote_req.offset < BIB_ROM_START + 48'h14;
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read");
    a_vendor_zero: assert property (reg_rd && reg_addr == BIB_OFS_VENDOR_ID |=>
        reg_rdata == 32'h0) else $error("vendor id not zero");
    a_map_align: assert property (reg_rd && reg_addr == BIB_OFS_ROM_MAP |=>
        reg_rdata[9:0] == 10'h0) else $error("map base low bits set");
    a_link_gate: assert property (remote_req.valid && !link_on |=>
        remote_rsp.kind == BIB_ANS_NONE) else $error("answer while link off");
    a_head_local: assert property (qrd && inr && head |=>
        remote_rsp.kind == BIB_ANS_LOCAL) else $error("header not local");
    a_bus_id: assert property (qrd && remote_req.offset == BIB_ROM_START + 48'h4 |=>
        remote_rsp.data == BIB_BUS_ID) else $error("bus id wrong");
    a_host_map: assert property (qrd && inr && !head |=>
        remote_rsp.kind == BIB_ANS_HOST &&
        remote_rsp.host_addr[9:0] == $past(remote_req.offset[9:0])) else $error("host map");
    a_type_err: assert property (remote_req.valid && link_on && inr &&
        remote_req.tcode != BIB_TC_QREAD |=> remote_rsp.kind == BIB_ANS_TYPERR)
        else $error("no type error");
    a_soft_off: assert property (soft_reset |=> !link_on[*2])
        else $error("link on after soft reset");
    a_rsp_once: assert property (!remote_req.valid |=> remote_rsp.kind == BIB_ANS_NONE)
        else $error("answer without request");
    c_host: cover property (qrd && inr && !head);
    c_local: cover property (qrd && inr && head);
    c_off: cover property (remote_req.valid && !link_on);
    c_soft: cover property (soft_reset);
endmodule : bib_regs_chk
bind bib_regs bib_regs_chk i_bib_regs_chk (.ref_clk, .resetn, .soft_reset, .reg_addr,
    .reg_rd, .reg_rdata, .remote_req, .remote_rsp, .link_on);

// >>> sim/tb_top.sv
// Self-checking bench for the information block register bank.
`timescale 1ns/1ps
module tb_top;
    import bib_pkg::*;
    localparam logic [31:0] OPT = 32'hf0a0_4ccf; // Max receive field 4: limit 32
    localparam logic [31:0] MAP = 32'h1234_57ff;
    localparam logic [31:0] UH = 32'h0a0b_0c0d;
    localparam logic [31:0] UL = 32'h1122_3344;
    localparam logic [63:0] RU = 64'h5a5a_0001_c3c3_0002;
    logic ref_clk = 0, resetn = 0, soft_reset = 0, reg_wr = 0, reg_rd = 0, fitted = 0;
    logic [7:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, hdr = 32'h0404_abcd;
    logic rom_present, rom_valid, rom_fetch, link_on;
    logic [63:0] rom_uid;
    bib_req_type remote_req = '0;
    bib_rsp_type remote_rsp;
    int miscompares = 0, total_checks = 0;
    bib_regs i_bib_regs (.ref_clk, .resetn, .soft_reset, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .rom_present, .rom_valid, .rom_uid, .rom_fetch,
        .rom_header(hdr), .remote_req, .remote_rsp, .link_on);
    bib_rom_model #(.UID(RU)) i_bib_rom_model (.ref_clk, .fitted, .rom_fetch,
        .rom_present, .rom_valid, .rom_uid);
    initial forever #50 ref_clk = ~ref_clk;
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic pwr_reset();
        @(posedge ref_clk) resetn <= 1'b0;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
    endtask : pwr_reset
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk) reg_wr <= 1'b0;
    endtask : wr
    // Data stands only in the cycle after the strobe
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk) reg_rd <= 1'b0;
        #1 chk("reg_rdata", reg_rdata, e);
    endtask : rd
    task automatic rq(logic [3:0] t, logic [47:0] o, logic [15:0] l, bib_ans_type k,
                      logic [31:0] d = 0);
        @(posedge ref_clk) remote_req <= '{1'b1, t, o, l};
        @(posedge ref_clk) remote_req.valid <= 1'b0;
        #1 chk("rsp_kind", remote_rsp.kind, k);
        if (k == BIB_ANS_LOCAL) chk("rsp_data", remote_rsp.data, d);
        if (k == BIB_ANS_HOST) chk("rsp_host", remote_rsp.host_addr, d);
    endtask : rq
    task automatic t_regs();
        rd(BIB_OFS_UID_HIGH, 0);
        rd(BIB_OFS_UID_LOW, 0);
        rd(BIB_OFS_STATUS, 32'h1);
        wr(BIB_OFS_BUS_OPTIONS, OPT);
        rd(BIB_OFS_BUS_OPTIONS, OPT);
        wr(BIB_OFS_ROM_MAP, MAP);
        rd(BIB_OFS_ROM_MAP, MAP & BIB_MAP_MASK);
        wr(BIB_OFS_VENDOR_ID, 32'hffff_ffff);
        rd(BIB_OFS_VENDOR_ID, 0);
        wr(8'h40, 32'h5555_aaaa);
        rd(8'h40, 0);
        wr(BIB_OFS_UID_HIGH, UH);
        wr(BIB_OFS_UID_LOW, UL);
        wr(BIB_OFS_UID_HIGH, ~UH);
        wr(BIB_OFS_UID_LOW, ~UL);
        rd(BIB_OFS_UID_HIGH, UH);
        rd(BIB_OFS_UID_LOW, UL);
        rd(BIB_OFS_STATUS, 32'h4);
    endtask : t_regs
    task automatic t_remote();
        logic [31:0] q [5];
        q = '{hdr, BIB_BUS_ID, OPT, UH, UL};
        rq(BIB_TC_QREAD, BIB_ROM_START, 4, BIB_ANS_NONE);
        wr(BIB_OFS_LINK_CTRL, 1);
        for (int i = 0; i < 5; i++) begin
            rq(BIB_TC_QREAD, BIB_ROM_START + 4 * i, 4, BIB_ANS_LOCAL, q[i]);
        end
        rq(BIB_TC_QREAD, BIB_ROM_START + 20, 4, BIB_ANS_HOST, 32'h1234_5414);
        rq(BIB_TC_QREAD, BIB_ROM_END - 3, 4, BIB_ANS_HOST, 32'h1234_57fc);
        rq(BIB_TC_BWRITE, BIB_ROM_START + 8, 4, BIB_ANS_TYPERR);
        rq(BIB_TC_BWRITE, 48'h1000, 33, BIB_ANS_TYPERR);
        rq(BIB_TC_BWRITE, 48'h1000, 32, BIB_ANS_NONE);
        // Largest receive size, programmed with the link off
        wr(BIB_OFS_LINK_CTRL, 0);
        wr(BIB_OFS_BUS_OPTIONS, OPT | 32'h0000_f000);
        wr(BIB_OFS_LINK_CTRL, 1);
        rq(BIB_TC_BWRITE, 48'h1000, 16'hffff, BIB_ANS_NONE);
        rq(BIB_TC_QREAD, BIB_ROM_START + 8, 4, BIB_ANS_LOCAL, OPT | 32'h0000_f000);
    endtask : t_remote
    task automatic t_soft();
        @(posedge ref_clk) soft_reset <= 1'b1;
        @(posedge ref_clk) soft_reset <= 1'b0;
        rd(BIB_OFS_LINK_CTRL, 0);
        rd(BIB_OFS_UID_HIGH, UH);
        rd(BIB_OFS_UID_LOW, UL);
        rq(BIB_TC_QREAD, BIB_ROM_START, 4, BIB_ANS_NONE);
    endtask : t_soft
    // Second power-up with the ROM fitted
    task automatic t_rom();
        @(posedge ref_clk) fitted <= 1'b1;
        pwr_reset();
        // Fetch rises one edge after release; the model answers 3 edges later
        @(posedge ref_clk);
        #1 chk("rom_fetch", rom_fetch, 1);
        repeat (3) @(posedge ref_clk);
        #1 chk("rom_fetch", rom_fetch, 1);
        @(posedge ref_clk);
        #1 chk("rom_fetch", rom_fetch, 0);
        wr(BIB_OFS_UID_LOW, UL);
        rd(BIB_OFS_UID_HIGH, RU[63:32]);
        rd(BIB_OFS_UID_LOW, RU[31:0]);
        rd(BIB_OFS_STATUS, 32'h4);
    endtask : t_rom
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    initial begin
        pwr_reset();
        t_regs();
        t_remote();
        t_soft();
        t_rom();
        give_verdict();
    end
    // Watchdog at 10000 cycles, far beyond the hundred or so cycles needed
    initial begin
        #1000000;
        miscompares++;
        give_verdict();
    end
endmodule : tb_top
